// ===== bench/gpp_pdu_pack_parse_test.sv
`timescale 1ns/1ps
`default_nettype none
module gpp_pdu_pack_parse_test;
    import gpp_pkg::*;
    typedef struct packed {
        logic [7:0]  t;
        logic [7:0]  c;
        logic        a;
        logic [63:0] v;
        logic [7:0]  n;
    } gpp_ev_s;
    typedef logic [7:0] gpp_oct_t[$];

    logic         clk, rst_b, rx_valid, rx_last, app_known, ev_valid, ev_all;
    logic [7:0]   rx_data, ev_type, ev_code, ev_vlen, fwd_data, tx_data;
    logic [255:0] type_known;
    logic [63:0]  ev_value, tx_in_value;
    logic         rx_err, fwd_valid, fwd_last, tx_in_valid, tx_in_ready;
    logic [7:0]   tx_in_type, tx_in_event;
    logic [3:0]   tx_in_vlen;
    logic         tx_valid, tx_last, tx_ready, slow;
    int           n_mismatch, checks_done, n_err;
    gpp_ev_s      evq[$];
    logic [8:0]   fwdq[$], expq[$];

    gpp_framer u_gpp_framer (.clk(clk), .rst_b(rst_b), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_last(rx_last), .app_known(app_known),
        .type_known(type_known), .ev_valid(ev_valid), .ev_type(ev_type),
        .ev_code(ev_code), .ev_all(ev_all), .ev_value(ev_value),
        .ev_vlen(ev_vlen), .rx_err(rx_err), .fwd_valid(fwd_valid),
        .fwd_data(fwd_data), .fwd_last(fwd_last), .tx_in_valid(tx_in_valid),
        .tx_in_type(tx_in_type), .tx_in_event(tx_in_event),
        .tx_in_value(tx_in_value), .tx_in_vlen(tx_in_vlen),
        .tx_in_ready(tx_in_ready), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_last(tx_last), .tx_ready(tx_ready));
    gpp_peer u_gpp_peer (.clk(clk), .rst_b(rst_b), .slow(slow),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
        .tx_ready(tx_ready));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if (ev_valid === 1'b1)
            evq.push_back({ev_type, ev_code, ev_all, ev_value, ev_vlen});
        if (rx_err === 1'b1)
            n_err++;
        if (fwd_valid === 1'b1)
            fwdq.push_back({fwd_last, fwd_data});
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chk_ev(gpp_ev_s exp);
        gpp_ev_s e;
        e = 'x;
        if (evq.size() > 0)
            e = evq.pop_front();
        checks_done++;
        if (e !== exp)
        begin
            n_mismatch++;
            $display("mismatch event expected %h seen %h", exp, e);
        end
    endtask : chk_ev

    // Frames may follow one another with no idle cycle between them
    task automatic send(gpp_oct_t b);
        foreach (b[i])
        begin
            rx_valid <= 1'b1;
            rx_data  <= b[i];
            rx_last  <= (i == b.size() - 1);
            @(posedge clk);
        end
    endtask : send

    task automatic idle();
        rx_valid <= 1'b0;
        rx_data  <= ~rx_data;
        rx_last  <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : idle

    task automatic t_rx_walk();
        send('{8'h00, 8'h01, 8'h05, 8'h04, 8'h02, 8'haa, 8'hbb, 8'h00, 8'h00});
        idle();
        chk_ev({8'h05, 8'h02, 1'b0, 64'haabb000000000000, 8'h02});
        chk("extra events", 0, evq.size());
    endtask : t_rx_walk

    task automatic t_rx_codes();
        gpp_oct_t b;
        b = '{8'h00, 8'h01, 8'h04};
        for (int c = 1; c <= 5; c++)
            b = {b, 8'h03, 8'(c), 8'(c)};
        send({b, 8'h00, 8'h00});
        idle();
        for (int c = 1; c <= 5; c++)
            chk_ev({8'h04, 8'(c), 1'b0, {8'(c), 56'h0}, 8'h01});
    endtask : t_rx_codes

    task automatic t_leave_all();
        send('{8'h00, 8'h01, 8'h05, 8'h02, 8'h00, 8'h03, 8'h01, 8'h11, 8'h00,
               8'h00});
        idle();
        chk_ev({8'h05, GPP_EV_LEAVE_ALL, 1'b1, 64'h0, 8'h00});
        chk_ev({8'h05, 8'h01, 1'b0, 64'h1100000000000000, 8'h01});
    endtask : t_leave_all

    task automatic t_skip();
        send('{8'h00, 8'h01, 8'h09, 8'h03, 8'h01, 8'haa, 8'h00, 8'h05, 8'h04,
               8'h07, 8'hbb, 8'hbb, 8'h04, 8'h02, 8'hcc, 8'hdd, 8'h00, 8'h00});
        idle();
        chk_ev({8'h05, 8'h02, 1'b0, 64'hccdd000000000000, 8'h02});
        chk("extra events", 0, evq.size());
    endtask : t_skip

    task automatic t_malformed();
        n_err = 0;
        send('{8'h00, 8'h02, 8'h05, 8'h04, 8'h02, 8'haa, 8'h00, 8'h00});
        send('{8'h00, 8'h01, 8'h05, 8'h01, 8'h04, 8'h02, 8'haa, 8'h00, 8'h00});
        idle();
        chk("error pulses", 2, n_err);
        chk("events after error", 0, evq.size());
    endtask : t_malformed

    task automatic t_trunc();
        send('{8'h00, 8'h01, 8'h05, 8'h04, 8'h02, 8'haa});
        send('{8'h00, 8'h01, 8'h05, 8'h03, 8'h01, 8'hcc});
        idle();
        chk_ev({8'h05, 8'h01, 1'b0, 64'hcc00000000000000, 8'h01});
        chk("extra events", 0, evq.size());
    endtask : t_trunc

    task automatic t_forward();
        gpp_oct_t b;
        b = '{8'h00, 8'h01, 8'h05, 8'h03, 8'h01, 8'h5a, 8'h00, 8'h00};
        app_known <= 1'b0;
        send(b);
        idle();
        app_known <= 1'b1;
        chk("forwarded count", b.size(), fwdq.size());
        foreach (b[i])
            chk("forwarded octet", {i == b.size() - 1, b[i]}, fwdq[i]);
        chk("events when forwarding", 0, evq.size());
    endtask : t_forward

    task automatic offer(logic [7:0] t, logic [7:0] e, logic [63:0] v,
                         logic [3:0] n);
        int k;
        k = 0;
        tx_in_valid <= 1'b1;
        tx_in_type  <= t;
        tx_in_event <= e;
        tx_in_value <= v;
        tx_in_vlen  <= n;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (tx_in_ready !== 1'b1 && k < 500);
        chk("attribute taken", 1, tx_in_ready);
    endtask : offer

    task automatic put_attr(logic [7:0] e, logic [63:0] v, int n);
        expq.push_back({1'b0, 8'(n + 2)});
        expq.push_back({1'b0, e});
        for (int j = 0; j < n; j++)
            expq.push_back({1'b0, v[63 - 8 * j -: 8]});
    endtask : put_attr

    task automatic tx_cmp();
        int k;
        k = 0;
        while (u_gpp_peer.got.size() < expq.size() && k < 3000)
        begin
            @(posedge clk);
            k++;
        end
        repeat (8) @(posedge clk);
        chk("tx octet count", expq.size(), u_gpp_peer.got.size());
        foreach (expq[i])
            chk("tx octet", expq[i], u_gpp_peer.got[i]);
        expq.delete();
        u_gpp_peer.got.delete();
    endtask : tx_cmp

    task automatic t_tx_mixed();
        slow <= 1'b1;
        offer(8'h03, 8'h02, 64'h7f00000000000000, 4'h1);
        offer(8'h03, 8'h05, 64'h1234000000000000, 4'h2);
        offer(8'h04, GPP_EV_LEAVE_ALL, 64'h0, 4'h5);
        tx_in_valid <= 1'b0;
        expq = '{9'h000, 9'h001, 9'h003};
        put_attr(8'h02, 64'h7f00000000000000, 1);
        put_attr(8'h05, 64'h1234000000000000, 2);
        expq = {expq, 9'h000, 9'h004, 9'h002, 9'h000, 9'h000, 9'h100};
        tx_cmp();
        slow <= 1'b0;
    endtask : t_tx_mixed

    task automatic t_tx_full();
        int fit;
        fit = (64 - 2 - 1 - 2) / 10;
        for (int a = 1; a <= fit + 1; a++)
            offer(8'h03, 8'h01, {8{8'(a)}}, 4'h8);
        tx_in_valid <= 1'b0;
        for (int f = 0; f < 2; f++)
        begin
            expq = {expq, 9'h000, 9'h001, 9'h003};
            for (int a = 1; a <= fit + 1; a++)
                if ((a > fit) == f)
                    put_attr(8'h01, {8{8'(a)}}, 8);
            expq = {expq, 9'h000, 9'h100};
        end
        tx_cmp();
    endtask : t_tx_full

    initial
    begin
        #60000;
        n_mismatch++;
        complete_run();
    end

    initial
    begin
        rst_b = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_last = 1'b0;
        app_known = 1'b1;
        type_known = '0;
        type_known[5:3] = 3'h7;
        tx_in_valid = 1'b0;
        tx_in_type = 8'h00;
        tx_in_event = 8'h00;
        tx_in_value = 64'h0;
        tx_in_vlen = 4'h0;
        slow = 1'b0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_rx_walk();
        t_rx_codes();
        t_leave_all();
        t_skip();
        t_malformed();
        t_trunc();
        t_forward();
        t_tx_mixed();
        t_tx_full();
        complete_run();
    end
endmodule : gpp_pdu_pack_parse_test
`default_nettype wire

// ===== bench/gpp_peer.sv
`timescale 1ns/1ps
`default_nettype none
module gpp_peer
(
    input  wire logic       clk,      // System clock
    input  wire logic       rst_b,    // Async reset, active low
    input  wire logic       slow,     // Stall the sink every third cycle
    input  wire logic       tx_valid, // Octet offered
    input  wire logic [7:0] tx_data,  // Octet
    input  wire logic       tx_last,  // Frame end
    output logic            tx_ready  // Octet taken
);
    logic [1:0] cnt_q;
    logic [8:0] got[$];

    // A slow sink shows that octets wait for acceptance and none is lost
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_q    <= 2'h0;
            tx_ready <= 1'b0;
        end
        else
        begin
            cnt_q    <= (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
            tx_ready <= !(slow && cnt_q == 2'h1);
            if (tx_valid === 1'b1 && tx_ready)
                got.push_back({tx_last, tx_data}); // Wire order kept
        end
    end
endmodule : gpp_peer
`default_nettype wire

// ===== core/gpp_framer.sv
`timescale 1ns/1ps
`default_nettype none
module gpp_framer
    import gpp_pkg::*;
(
    input  wire logic         clk,          // 250 MHz system clock
    input  wire logic         rst_b,        // Async reset, active low
    input  wire logic         rx_valid,     // Received octet present
    input  wire logic [7:0]   rx_data,      // Received octet
    input  wire logic         rx_last,      // Last octet of the frame
    input  wire logic         app_known,    // Application is implemented
    input  wire logic [255:0] type_known,   // Recognised attribute types
    output logic              ev_valid,     // Decoded event pulse
    output logic [7:0]        ev_type,      // Attribute type of event
    output logic [7:0]        ev_code,      // Event code
    output logic              ev_all,       // Event is leave-all
    output logic [63:0]       ev_value,     // Value, first octet on top
    output logic [7:0]        ev_vlen,      // Value length in octets
    output logic              rx_err,       // Malformed frame pulse
    output logic              fwd_valid,    // Forwarded octet present
    output logic [7:0]        fwd_data,     // Forwarded octet
    output logic              fwd_last,     // Forwarded frame end
    input  wire logic         tx_in_valid,  // Attribute offered to send
    input  wire logic [7:0]   tx_in_type,   // Its attribute type
    input  wire logic [7:0]   tx_in_event,  // Its event code
    input  wire logic [63:0]  tx_in_value,  // Value, first octet on top
    input  wire logic [3:0]   tx_in_vlen,   // Value length, 0 to 8
    output logic              tx_in_ready,  // Attribute taken
    output logic              tx_valid,     // Transmit octet present
    output logic [7:0]        tx_data,      // Transmit octet
    output logic              tx_last,      // Last octet of the frame
    input  wire logic         tx_ready      // Sink accepts octet
);

    gpp_rx_s r_q;
    gpp_rx_s r_d;
    gpp_tx_s t_q;
    gpp_tx_s t_d;
    logic        done;
    logic        adv;
    logic        emit;
    logic [7:0]  obyte;
    logic        okind_type;
    logic        okind_len;
    logic [10:0] need;
    logic [10:0] room;

    // Receive parser: one octet per cycle, no back-pressure
    always_comb
    begin
        r_d = r_q;
        done = 1'b0;
        r_d.ev_valid = 1'b0;
        r_d.err = 1'b0;
        r_d.fwd_valid = rx_valid & ~app_known;
        r_d.fwd_data = rx_data;
        r_d.fwd_last = rx_last;
        if (rx_valid)
        begin
            case (r_q.st)
                GPP_P_PID0:
                begin
                    r_d.pid_hi = rx_data;
                    r_d.st = GPP_P_PID1;
                end
                GPP_P_PID1:
                begin
                    if ({r_q.pid_hi, rx_data} == GPP_PROTO_ID)
                        r_d.st = GPP_P_TYPE;
                    else
                    begin
                        r_d.err = 1'b1;
                        r_d.st = GPP_P_SKIP;
                    end
                end
                GPP_P_TYPE:
                begin
                    if (rx_data == GPP_END_MARK)
                        r_d.st = GPP_P_SKIP;
                    else
                    begin
                        r_d.mtype = rx_data;
                        r_d.mknown = type_known[rx_data];
                        r_d.st = GPP_P_LEN;
                    end
                end
                GPP_P_LEN:
                begin
                    if (rx_data == GPP_END_MARK)
                        r_d.st = GPP_P_TYPE;
                    else if (rx_data < GPP_LEN_MIN)
                    begin
                        r_d.err = 1'b1;
                        r_d.st = GPP_P_SKIP;
                    end
                    else
                    begin
                        r_d.alen = rx_data;
                        r_d.rem = rx_data - GPP_LEN_MIN;
                        r_d.st = GPP_P_EV;
                    end
                end
                GPP_P_EV:
                begin
                    r_d.ev = rx_data;
                    r_d.idx = 4'h0;
                    r_d.val = 64'h0;
                    if (r_q.rem == 8'h00)
                    begin
                        done = 1'b1;
                        r_d.st = GPP_P_LEN;
                    end
                    else
                        r_d.st = GPP_P_VAL;
                end
                GPP_P_VAL:
                begin
                    // Octets past the buffer are counted but not kept
                    if (r_q.idx < GPP_VAL_MAX)
                    begin
                        r_d.val[(7 - r_q.idx[2:0]) * 8 +: 8] = rx_data;
                        r_d.idx = r_q.idx + 4'h1;
                    end
                    r_d.rem = r_q.rem - 8'h01;
                    if (r_q.rem == 8'h01)
                    begin
                        done = 1'b1;
                        r_d.st = GPP_P_LEN;
                    end
                end
                GPP_P_SKIP:
                    r_d.st = GPP_P_SKIP;
                default:
                    r_d.st = GPP_P_PID0;
            endcase
            if (rx_last)
                r_d.st = GPP_P_PID0;
        end
        // Partial attributes never reach done, so they vanish here
        if (done && app_known && r_q.mknown
            && r_d.ev <= GPP_EV_EMPTY)
        begin
            r_d.ev_valid = 1'b1;
            r_d.ev_type = r_q.mtype;
            r_d.ev_code = r_d.ev;
            r_d.ev_all = (r_d.ev == GPP_EV_LEAVE_ALL);
            r_d.ev_value = r_d.val;
            r_d.ev_vlen = r_q.alen - GPP_LEN_MIN;
        end
    end

    // Transmit packer; the output octet register holds while stalled
    always_comb
    begin
        t_d = t_q;
        adv = ~t_q.tx_valid | tx_ready;
        emit = 1'b0;
        obyte = GPP_END_MARK;
        okind_type = 1'b0;
        okind_len = 1'b0;
        need = 11'h0;
        room = GPP_FRAME_MAX - t_q.pos;
        t_d.in_ready = 1'b0;
        if (t_q.st == GPP_T_NEXT)
        begin
            if (tx_in_event == GPP_EV_LEAVE_ALL)
                need = {3'h0, GPP_LEN_MIN} + GPP_TAIL_LEN;
            else
                need = {3'h0, GPP_LEN_MIN} + {7'h0, tx_in_vlen} + GPP_TAIL_LEN;
            if (tx_in_type != t_q.ctype)
                need = need + GPP_MSG_OPEN;
        end
        case (t_q.st)
            GPP_T_IDLE:
            begin
                if (tx_in_valid)
                begin
                    t_d.start = 1'b1;
                    t_d.newmsg = 1'b1;
                    t_d.in_ready = 1'b1;
                    t_d.st = GPP_T_TAKE;
                end
            end
            GPP_T_TAKE:
            begin
                t_d.ctype = tx_in_type;
                t_d.cev = tx_in_event;
                t_d.cval = tx_in_value;
                t_d.cvlen = (tx_in_event == GPP_EV_LEAVE_ALL) ? 4'h0
                                                               : tx_in_vlen;
                t_d.vcnt = 4'h0;
                t_d.close = 1'b0;
                if (t_q.start)
                    t_d.st = GPP_T_PID0;
                else if (t_q.newmsg)
                    t_d.st = GPP_T_ENDL;
                else
                    t_d.st = GPP_T_LEN;
            end
            GPP_T_PID0:
            begin
                emit = 1'b1;
                obyte = GPP_PROTO_ID[15:8];
                if (adv)
                    t_d.st = GPP_T_PID1;
            end
            GPP_T_PID1:
            begin
                emit = 1'b1;
                obyte = GPP_PROTO_ID[7:0];
                if (adv)
                    t_d.st = GPP_T_TYPE;
            end
            GPP_T_TYPE:
            begin
                emit = 1'b1;
                okind_type = 1'b1;
                obyte = t_q.ctype;
                if (adv)
                    t_d.st = GPP_T_LEN;
            end
            GPP_T_LEN:
            begin
                emit = 1'b1;
                okind_len = 1'b1;
                obyte = GPP_LEN_MIN + {4'h0, t_q.cvlen};
                if (adv)
                    t_d.st = GPP_T_EV;
            end
            GPP_T_EV:
            begin
                emit = 1'b1;
                obyte = t_q.cev;
                if (adv)
                    t_d.st = (t_q.cvlen == 4'h0) ? GPP_T_NEXT : GPP_T_VAL;
            end
            GPP_T_VAL:
            begin
                emit = 1'b1;
                obyte = t_q.cval[63:56];
                if (adv)
                begin
                    t_d.cval = {t_q.cval[55:0], 8'h00};
                    t_d.vcnt = t_q.vcnt + 4'h1;
                    if (t_q.vcnt == t_q.cvlen - 4'h1)
                        t_d.st = GPP_T_NEXT;
                end
            end
            GPP_T_NEXT:
            begin
                // Whole attributes only: a tail that would not fit waits
                t_d.start = 1'b0;
                t_d.newmsg = (tx_in_type != t_q.ctype);
                if (tx_in_valid && need <= room)
                begin
                    t_d.in_ready = 1'b1;
                    t_d.st = GPP_T_TAKE;
                end
                else
                begin
                    t_d.close = 1'b1;
                    t_d.st = GPP_T_ENDL;
                end
            end
            GPP_T_ENDL:
            begin
                emit = 1'b1;
                obyte = GPP_END_MARK;
                if (adv)
                    t_d.st = t_q.close ? GPP_T_ENDP : GPP_T_TYPE;
            end
            GPP_T_ENDP:
            begin
                emit = 1'b1;
                obyte = GPP_END_MARK;
                if (adv)
                    t_d.st = GPP_T_IDLE;
            end
            default:
                t_d.st = GPP_T_IDLE;
        endcase
        if (adv)
        begin
            t_d.tx_valid = emit;
            t_d.tx_data = obyte;
            t_d.tx_last = emit && (t_q.st == GPP_T_ENDP);
            t_d.tx_is_type = okind_type;
            t_d.tx_is_len = okind_len;
            if (emit)
                t_d.pos = (t_q.st == GPP_T_ENDP) ? 11'h0 : t_q.pos + 11'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            r_q <= '0;
            t_q <= '0;
        end
        else
        begin
            r_q <= r_d;
            t_q <= t_d;
        end
    end

    assign ev_valid    = r_q.ev_valid;
    assign ev_type     = r_q.ev_type;
    assign ev_code     = r_q.ev_code;
    assign ev_all      = r_q.ev_all;
    assign ev_value    = r_q.ev_value;
    assign ev_vlen     = r_q.ev_vlen;
    assign rx_err      = r_q.err;
    assign fwd_valid   = r_q.fwd_valid;
    assign fwd_data    = r_q.fwd_data;
    assign fwd_last    = r_q.fwd_last;
    assign tx_in_ready = t_q.in_ready;
    assign tx_valid    = t_q.tx_valid;
    assign tx_data     = t_q.tx_data;
    assign tx_last     = t_q.tx_last;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_fwd_copy: assert property (rx_valid && !app_known |=>
        fwd_valid && fwd_data == $past(rx_data))
        else $error("unsupported frame octet not forwarded");
    a_pid_bad_err: assert property (rx_valid && r_q.st == GPP_P_PID1
        && {r_q.pid_hi, rx_data} != GPP_PROTO_ID |=> rx_err)
        else $error("bad identifier not flagged");
    a_ev_code_known: assert property (ev_valid |->
        ev_code <= GPP_EV_EMPTY && type_known[ev_type])
        else $error("unknown event or type delivered");
    a_leave_all_flag: assert property (ev_valid |->
        ev_all == (ev_code == GPP_EV_LEAVE_ALL))
        else $error("leave-all flag wrong");
    a_trunc_drop: assert property (rx_valid && rx_last
        && r_q.st == GPP_P_VAL && r_q.rem > 8'h01 |=> !ev_valid)
        else $error("truncated attribute delivered");
    a_tx_frame_fit: assert property (tx_valid |->
        t_q.pos <= GPP_FRAME_MAX)
        else $error("frame longer than limit");
    a_tx_type_nz: assert property (tx_valid && t_q.tx_is_type |->
        tx_data != 8'h00)
        else $error("zero attribute type sent");
    a_tx_len_min: assert property (tx_valid && t_q.tx_is_len |->
        tx_data >= GPP_LEN_MIN)
        else $error("attribute length below two");
    a_tx_end_zero: assert property (tx_valid && tx_last |->
        tx_data == GPP_END_MARK && $past(tx_data) == GPP_END_MARK)
        else $error("frame not closed by end marks");
    a_tx_pid_order: assert property (t_q.st == GPP_T_PID0 && adv |=>
        tx_valid && tx_data == 8'h00 && t_q.st == GPP_T_PID1)
        else $error("identifier high octet wrong");
    a_tx_stall_hold: assert property (tx_valid && !tx_ready |=>
        tx_valid && $stable(tx_data) && $stable(tx_last))
        else $error("octet changed while stalled");

    c_leave_all: cover property (ev_valid && ev_all);
    c_rx_err: cover property (rx_err);
    c_tx_frame: cover property (tx_valid && tx_ready && tx_last);
    c_fwd: cover property (fwd_valid && fwd_last);

endmodule : gpp_framer
`default_nettype wire

// ===== core/gpp_pkg.sv
package gpp_pkg;

    localparam logic [15:0] GPP_PROTO_ID     = 16'h0001;
    localparam logic [7:0]  GPP_END_MARK     = 8'h00;
    localparam logic [7:0]  GPP_EV_LEAVE_ALL = 8'h00;
    localparam logic [7:0]  GPP_EV_JOIN_EMPT = 8'h01;
    localparam logic [7:0]  GPP_EV_JOIN_IN   = 8'h02;
    localparam logic [7:0]  GPP_EV_LEAVE_EMP = 8'h03;
    localparam logic [7:0]  GPP_EV_LEAVE_IN  = 8'h04;
    localparam logic [7:0]  GPP_EV_EMPTY     = 8'h05;
    localparam logic [7:0]  GPP_LEN_MIN      = 8'h02;
    localparam logic [3:0]  GPP_VAL_MAX      = 4'h8;
    localparam logic [10:0] GPP_FRAME_MAX    = 11'h040;
    localparam logic [10:0] GPP_TAIL_LEN     = 11'h002;
    localparam logic [10:0] GPP_MSG_OPEN     = 11'h002;

    typedef enum logic [2:0] {
        GPP_P_PID0, GPP_P_PID1, GPP_P_TYPE, GPP_P_LEN,
        GPP_P_EV, GPP_P_VAL, GPP_P_SKIP
    } gpp_rx_e;

    typedef enum logic [3:0] {
        GPP_T_IDLE, GPP_T_TAKE, GPP_T_PID0, GPP_T_PID1, GPP_T_TYPE,
        GPP_T_LEN, GPP_T_EV, GPP_T_VAL, GPP_T_NEXT, GPP_T_ENDL, GPP_T_ENDP
    } gpp_tx_e;

    typedef struct packed {
        gpp_rx_e     st;
        logic [7:0]  pid_hi;
        logic [7:0]  mtype;
        logic        mknown;
        logic [7:0]  alen;
        logic [7:0]  rem;
        logic [7:0]  ev;
        logic [3:0]  idx;
        logic [63:0] val;
        logic        ev_valid;
        logic [7:0]  ev_type;
        logic [7:0]  ev_code;
        logic        ev_all;
        logic [63:0] ev_value;
        logic [7:0]  ev_vlen;
        logic        err;
        logic        fwd_valid;
        logic [7:0]  fwd_data;
        logic        fwd_last;
    } gpp_rx_s;

    typedef struct packed {
        gpp_tx_e     st;
        logic [10:0] pos;
        logic        start;
        logic        newmsg;
        logic        close;
        logic [7:0]  ctype;
        logic [7:0]  cev;
        logic [63:0] cval;
        logic [3:0]  cvlen;
        logic [3:0]  vcnt;
        logic        in_ready;
        logic        tx_valid;
        logic [7:0]  tx_data;
        logic        tx_last;
        logic        tx_is_type;
        logic        tx_is_len;
    } gpp_tx_s;

endpackage : gpp_pkg
